// *** src/wdt_consts.vh ***
// constants for the lockable crash recovery timer: offsets, fields, reset values, counts
// assumes a single 32-bit register bus and a low-speed count clock sampled as a plain input
//
// Overview of operation
// - 32-bit counter counts down once per low-speed clock cycle, 32.768 kHz
// - on reaching zero, raw interrupt status sets and counter reloads from reload_value
// - interrupts repeat every reload_value plus 1 low-speed periods
// - clearing the interrupt reloads the counter from reload_value
// - zero reached again with status uncleared issues system reset when reset enabled
// - counter stops while interrupt disabled; enabling restarts it from reload_value
// - writing 0x1acce551 to write_lock unlocks other registers; other values lock them
// - writing reload_value restarts counting from the new value; resets to 0x0fffffff
// - current_count reads the live counter; writes to it are ignored
// - control bit 0 enables interrupt generation; resets to 0
// - control bit 1 enables the reset output; resets to 0
// - raw status read-only at 0x10, masked status read-only at 0x14
// - any write to interrupt_clear clears interrupt and reloads; it reads zero
// - write_lock reads 0 while unlocked and 1 while locked
`ifndef WDT_CONSTS_VH
`define WDT_CONSTS_VH

// register byte offsets
`define OFS_RELOAD_VALUE 12'h000
`define OFS_CURRENT_COUNT 12'h004
`define OFS_CONTROL 12'h008
`define OFS_INTERRUPT_CLEAR 12'h00c
`define OFS_RAW_STATUS 12'h010
`define OFS_MASKED_STATUS 12'h014
`define OFS_WRITE_LOCK 12'hc00
`define ADDR_DECODE_BITS 12

// field positions
`define CTRL_IRQ_ENABLE_BIT 0
`define CTRL_RESET_OUT_ENABLE_BIT 1

// reset values and keys
`define RELOAD_RESET_VALUE 32'h0fffffff
`define CONTROL_RESET_VALUE 2'h0
`define UNLOCK_KEY 32'h1acce551

// timing
`define LSCLK_FREQ_HZ 32768
`define SYS_RESET_PULSE_CYCLES 5'h10

// bus encodings
`define HTRANS_NONSEQ_BIT 1
`define HRESP_OKAY 1'b0

`endif

// *** src/edge_sync.v ***
// two-flop synchroniser with rising edge detector for the low-speed count clock
// assumes the input is slow compared to clk, at least three clk periods per level
`timescale 1ns/100ps
`default_nettype none
module edge_sync (
  // clock and reset
  input wire clk,
  input wire rst_n,
  // asynchronous level in
  input wire async_in,
  // one-cycle pulse on each rising edge
  output wire rise_pulse
);
  reg meta_q;
  reg sync_q;
  reg prev_q;
  reg rise_q;

  // only sync_q reads meta_q
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      prev_q <= 1'b0;
      rise_q <= 1'b0;
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
      prev_q <= sync_q;
      rise_q <= sync_q & ~prev_q;
    end
  end

  assign rise_pulse = rise_q;
endmodule
`default_nettype wire

// *** src/watchdog_timer_lockable.v ***
// lockable crash recovery timer with an AHB-Lite register slave
// assumes one hclk domain; the 32.768 kHz count clock arrives as a plain input pin
`timescale 1ns/100ps
`default_nettype none
`include "wdt_consts.vh"
module watchdog_timer_lockable (
  // clock and reset
  input wire hclk,
  input wire hresetn,
  // ahb-lite slave
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output wire [31:0] hrdata,
  output wire hreadyout,
  output wire hresp,
  // low-speed count clock
  input wire lsclk,
  // interrupt and system reset request
  output wire irq,
  output wire sys_reset
);
  // bus phase states
  localparam [1:0] ST_IDLE = 2'b00;
  localparam [1:0] ST_ACCESS = 2'b01;
  localparam [1:0] ST_DONE = 2'b10;

  reg [1:0] state_q;
  reg [1:0] state_d;
  reg [`ADDR_DECODE_BITS-1:0] addr_q;
  reg write_q;
  reg [31:0] hrdata_q;
  reg hreadyout_q;
  reg hresp_q;

  reg [31:0] reload_q;
  reg [31:0] count_q;
  reg [31:0] count_d;
  reg irq_en_q;
  reg irq_en_d;
  reg rst_en_q;
  reg rst_en_d;
  reg raw_q;
  reg raw_d;
  reg locked_q;
  reg irq_q;
  reg [4:0] rst_cnt_q;
  reg sys_reset_q;

  wire tick;
  wire accept;
  wire wr_now;
  wire wr_ok;
  wire wr_reload;
  wire wr_control;
  wire wr_clear;
  wire wr_lock;
  wire enable_rise;
  wire zero_event;
  wire fire_reset;
  wire run_tick;
  wire count_at_zero;
  wire masked_d;
  wire pulse_more;
  wire [31:0] rd_value;

  // register index decode, used for both reads and writes
  function is_reg;
    input [`ADDR_DECODE_BITS-1:0] a;
    input [`ADDR_DECODE_BITS-1:0] ofs;
    begin
      is_reg = (a == ofs);
    end
  endfunction

  // terminal count detect, shared by the status logic and the counter
  function is_zero;
    input [31:0] value;
    begin
      is_zero = (value == 32'h00000000);
    end
  endfunction

  // read multiplexer; unmapped addresses read as zero
  function [31:0] read_mux;
    input [`ADDR_DECODE_BITS-1:0] a;
    input [31:0] reload;
    input [31:0] count;
    input ien;
    input ren;
    input raw;
    input locked;
    begin
      read_mux = 32'h00000000;
      if (is_reg(a, `OFS_RELOAD_VALUE)) begin
        read_mux = reload;
      end else if (is_reg(a, `OFS_CURRENT_COUNT)) begin
        read_mux = count;
      end else if (is_reg(a, `OFS_CONTROL)) begin
        read_mux = {30'h00000000, ren, ien};
      end else if (is_reg(a, `OFS_INTERRUPT_CLEAR)) begin
        read_mux = 32'h00000000;
      end else if (is_reg(a, `OFS_RAW_STATUS)) begin
        read_mux = {31'h00000000, raw};
      end else if (is_reg(a, `OFS_MASKED_STATUS)) begin
        read_mux = {31'h00000000, raw & ien};
      end else if (is_reg(a, `OFS_WRITE_LOCK)) begin
        read_mux = {31'h00000000, locked};
      end
    end
  endfunction

  // count clock edges reach the counter only after synchronisation
  edge_sync u_lsclk_sync (
    .clk(hclk),
    .rst_n(hresetn),
    .async_in(lsclk),
    .rise_pulse(tick)
  );

  // address phase is taken when selected, nonseq or seq, and the bus is ready
  assign accept = hsel & htrans[`HTRANS_NONSEQ_BIT] & hready;

  always @* begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (accept) begin
          state_d = ST_ACCESS;
        end
      end
      ST_ACCESS: begin
        state_d = ST_DONE;
      end
      ST_DONE: begin
        if (accept) begin
          state_d = ST_ACCESS;
        end else begin
          state_d = ST_IDLE;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  // one wait state per transfer so a read after a write sees the new value
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q <= ST_IDLE;
      addr_q <= {`ADDR_DECODE_BITS{1'b0}};
      write_q <= 1'b0;
      hreadyout_q <= 1'b1;
      hrdata_q <= 32'h00000000;
      hresp_q <= `HRESP_OKAY;
    end else begin
      state_q <= state_d;
      hresp_q <= `HRESP_OKAY;
      if (accept) begin
        addr_q <= haddr[`ADDR_DECODE_BITS-1:0];
        write_q <= hwrite;
        hreadyout_q <= 1'b0;
      end else if (state_q == ST_ACCESS) begin
        hreadyout_q <= 1'b1;
      end
      if (state_q == ST_ACCESS && !write_q) begin
        hrdata_q <= rd_value;
      end
    end
  end

  assign rd_value = read_mux(addr_q, reload_q, count_q, irq_en_q, rst_en_q, raw_q, locked_q);

  // write strobes, valid in the first data-phase cycle
  assign wr_now = (state_q == ST_ACCESS) & write_q;
  assign wr_ok = wr_now & ~locked_q;
  assign wr_reload = wr_ok & is_reg(addr_q, `OFS_RELOAD_VALUE);
  assign wr_control = wr_ok & is_reg(addr_q, `OFS_CONTROL);
  assign wr_clear = wr_ok & is_reg(addr_q, `OFS_INTERRUPT_CLEAR);
  assign wr_lock = wr_now & is_reg(addr_q, `OFS_WRITE_LOCK);
  assign enable_rise = wr_control & hwdata[`CTRL_IRQ_ENABLE_BIT] & ~irq_en_q;

  // lock register, writable whether locked or not
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      locked_q <= 1'b0;
    end else if (wr_lock) begin
      locked_q <= (hwdata != `UNLOCK_KEY);
    end
  end

  // reload value and control bits
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      reload_q <= `RELOAD_RESET_VALUE;
      irq_en_q <= 1'b0;
      rst_en_q <= 1'b0;
    end else begin
      if (wr_reload) begin
        reload_q <= hwdata;
      end
      irq_en_q <= irq_en_d;
      rst_en_q <= rst_en_d;
    end
  end

  // next control state, shared by the control flops and the interrupt line
  always @* begin
    irq_en_d = irq_en_q;
    rst_en_d = rst_en_q;
    if (wr_control) begin
      irq_en_d = hwdata[`CTRL_IRQ_ENABLE_BIT];
      rst_en_d = hwdata[`CTRL_RESET_OUT_ENABLE_BIT];
    end
  end

  // a tick only moves the counter while interrupt generation runs it
  assign run_tick = tick & irq_en_q;
  assign count_at_zero = is_zero(count_q);

  // zero is reached on a count edge while running
  assign zero_event = run_tick & count_at_zero;

  // a second zero with status still set; a clear in the same cycle serves the first one
  assign fire_reset = zero_event & raw_q & ~wr_clear & rst_en_q;

  always @* begin
    count_d = count_q;
    if (wr_reload) begin
      count_d = hwdata;
    end else if (wr_clear || enable_rise) begin
      count_d = reload_q;
    end else if (run_tick) begin
      if (count_at_zero) begin
        count_d = reload_q;
      end else begin
        count_d = count_q - 32'h00000001;
      end
    end
  end

  // set wins over a clear arriving in the same cycle
  always @* begin
    raw_d = raw_q;
    if (wr_clear) begin
      raw_d = 1'b0;
    end
    if (zero_event) begin
      raw_d = 1'b1;
    end
  end

  // counter holds while disabled; the next enable reloads it
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count_q <= `RELOAD_RESET_VALUE;
      raw_q <= 1'b0;
    end else begin
      count_q <= count_d;
      raw_q <= raw_d;
    end
  end

  // interrupt line is the masked status, registered from the next status and enable
  assign masked_d = raw_d & irq_en_d;

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= masked_d;
    end
  end

  // the pulse counts down to one, then the request drops
  assign pulse_more = (rst_cnt_q > 5'h01);

  // reset request is stretched so a slow reset controller cannot miss it
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rst_cnt_q <= 5'h00;
      sys_reset_q <= 1'b0;
    end else begin
      if (fire_reset) begin
        rst_cnt_q <= `SYS_RESET_PULSE_CYCLES;
        sys_reset_q <= 1'b1;
      end else if (pulse_more) begin
        rst_cnt_q <= rst_cnt_q - 5'h01;
      end else begin
        rst_cnt_q <= 5'h00;
        sys_reset_q <= 1'b0;
      end
    end
  end

  assign hrdata = hrdata_q;
  assign hreadyout = hreadyout_q;
  assign hresp = hresp_q;
  assign irq = irq_q;
  assign sys_reset = sys_reset_q;
endmodule
`default_nettype wire

// *** testbench/watchdog_timer_lockable_properties.sv ***
// port assertions for the lockable crash recovery timer
// assumes one hclk domain, hresetn async active low
`timescale 1ns/100ps
`default_nettype none
module watchdog_timer_lockable_properties (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // bus
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  // outputs
  input wire logic irq,
  input wire logic sys_reset
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic rd;
  assign rd = hsel && htrans[1] && hready && !hwrite;
  property p_wait; hsel && htrans[1] && hready |=> !hreadyout ##1 hreadyout; endproperty
  a_wait: assert property (p_wait) else $error("wait state wrong");
  property p_okay; hresp == 1'b0; endproperty
  a_okay: assert property (p_okay) else $error("response not okay");
  property p_pulse; $rose(sys_reset) |-> sys_reset [*8] ##1 sys_reset [*8] ##1 !sys_reset; endproperty
  a_pulse: assert property (p_pulse) else $error("reset pulse length");
  property p_cause; $rose(sys_reset) |-> $past(irq); endproperty
  a_cause: assert property (p_cause) else $error("reset without pending irq");
  property p_clr; rd && haddr[11:0] == 12'h00c |-> ##2 hrdata == 32'h0; endproperty
  a_clr: assert property (p_clr) else $error("clear reg not zero");
  property p_raw; rd && haddr[11:0] == 12'h010 |-> ##2 hrdata[31:1] == 31'h0; endproperty
  a_raw: assert property (p_raw) else $error("raw status upper bits");
  property p_mis; rd && haddr[11:0] == 12'h014 |-> ##2 hrdata[31:1] == 31'h0; endproperty
  a_mis: assert property (p_mis) else $error("masked status upper bits");
  property p_rst; $rose(hresetn) |-> !irq && !sys_reset; endproperty
  a_rst: assert property (p_rst) else $error("outputs active after reset");
endmodule
bind watchdog_timer_lockable watchdog_timer_lockable_properties chk_u (.hclk(hclk), .hresetn(hresetn),
  .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
  .hreadyout(hreadyout), .hresp(hresp), .irq(irq), .sys_reset(sys_reset));
`default_nettype wire

// *** testbench/test_watchdog_timer_lockable.sv ***
// self-checking bench for the lockable crash recovery timer
// assumes hready tied to hreadyout; lsclk made here near 32.768 kHz
`timescale 1ns/100ps
`default_nettype none
`include "wdt_consts.vh"
module test_watchdog_timer_lockable;
  localparam int lsp = 3814; // hclk cycles per lsclk period
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, lsclk = 0;
  logic [31:0] haddr = 0, hwdata = 0, q, r, v;
  logic [1:0] htrans = 0;
  wire logic [31:0] hrdata;
  wire logic hreadyout, hresp, irq, sys_reset;
  int seed = 57, miscompares = 0, comparisons = 0, n, lsc = 0;
  logic [11:0] ra [8] = '{12'h000, 12'h004, 12'h008, 12'h00c, 12'h010, 12'h014, 12'hc00, 12'h020};
  logic [31:0] rv [8] = '{`RELOAD_RESET_VALUE, `RELOAD_RESET_VALUE, 0, 0, 0, 0, 0, 0};
  always #4 hclk = ~hclk;
  // count clock kept in step with hclk so tick spacing is an exact number of cycles
  always @(posedge hclk) begin
    if (lsc == lsp / 2 - 1) begin
      lsc <= 0;
      lsclk <= ~lsclk;
    end else begin
      lsc <= lsc + 1;
    end
  end
  watchdog_timer_lockable dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .lsclk(lsclk), .irq(irq), .sys_reset(sys_reset));
  task automatic results;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // bounded wait on hready; a hang ends the run
  task automatic rdy;
    int i;
    i = 0;
    do begin
      @(posedge hclk);
      i++;
    end while (hreadyout !== 1'b1 && i < 50);
    if (hreadyout !== 1'b1) begin
      miscompares++;
      results;
    end
  endtask
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {20'h0, a};
    rdy;
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    rdy;
    q = hrdata;
  endtask
  task automatic wait_hi(input logic sel, input int lim);
    n = 0;
    while ((sel ? sys_reset : irq) !== 1'b1 && n < lim) begin
      @(posedge hclk);
      n++;
    end
    if (n >= lim) begin
      miscompares++;
      results;
    end
  endtask
  initial begin
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    foreach (ra[i]) begin
      xfer(1'b0, ra[i], 0);
      chk("reset value", q, rv[i]);
    end
    $display("test reset_values done");
    // low bit cleared so the value can never be the key
    v = $random(seed) & 32'hfffffffe;
    xfer(1'b1, 12'hc00, v);
    xfer(1'b0, 12'hc00, 0);
    chk("lock status", q, 1);
    xfer(1'b1, 12'h000, 32'h5);
    xfer(1'b0, 12'h000, 0);
    chk("locked reload", q, `RELOAD_RESET_VALUE);
    xfer(1'b1, 12'hc00, `UNLOCK_KEY);
    xfer(1'b0, 12'hc00, 0);
    chk("unlock status", q, 0);
    $display("test lock done");
    r = 2 + ($random(seed) & 1);
    xfer(1'b1, 12'h000, r);
    xfer(1'b1, 12'h004, 32'h0);
    xfer(1'b0, 12'h004, 0);
    chk("count", q, r);
    xfer(1'b1, 12'h008, 32'h1);
    wait_hi(1'b0, (r + 1) * lsp + 50);
    chk("interval", n > r * lsp - 10, 1);
    xfer(1'b0, 12'h010, 0);
    chk("raw", q, 1);
    xfer(1'b0, 12'h004, 0);
    chk("reloaded", q, r);
    xfer(1'b0, 12'h014, 0);
    chk("masked", q, 1);
    xfer(1'b1, 12'h008, 32'h0);
    xfer(1'b0, 12'h014, 0);
    chk("masked off", q, 0);
    chk("irq off", irq, 0);
    xfer(1'b1, 12'h00c, $random(seed));
    xfer(1'b0, 12'h010, 0);
    chk("cleared", q, 0);
    $display("test count done");
    xfer(1'b1, 12'h008, 32'h3);
    xfer(1'b1, 12'hc00, v);
    xfer(1'b1, 12'h008, 32'h0);
    wait_hi(1'b0, (r + 1) * lsp + 50);
    wait_hi(1'b1, (r + 1) * lsp + 50);
    chk("system reset", sys_reset, 1);
    chk("reset interval", n, (r + 1) * lsp);
    $display("test reset_out done");
    // reboot as the reset request would; registers and lock must come back to reset values
    repeat (20) @(posedge hclk);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    foreach (ra[i]) begin
      xfer(1'b0, ra[i], 0);
      chk("reset again", q, rv[i]);
    end
    $display("test reboot done");
    results;
  end
endmodule
`default_nettype wire
